// File: hdl/elr_pkg.sv
// shared constants and types for the encoder link receiver
`default_nettype none
package elr_pkg;
    // link timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int unsigned BIT_RATE_BPS = 2_500_000;
    localparam int unsigned BIT_CYCLES = CLK_HZ / BIT_RATE_BPS;
    localparam logic [2:0] BIT_LAST = 3'(BIT_CYCLES - 1);
    localparam logic [2:0] HALF_LAST = 3'(BIT_CYCLES / 2 - 1);
    localparam logic [3:0] FRAME_BITS = 4'hA;
    localparam int unsigned REPLY_TIMEOUT_NS = 40_000;
    localparam int unsigned TIMEOUT_CYCLES = REPLY_TIMEOUT_NS / CLK_PERIOD_NS;
    localparam logic [9:0] TIMEOUT_LAST = 10'(TIMEOUT_CYCLES - 1);

    // register offsets (word index on the plain register port)
    localparam logic [3:0] OFS_FIRMWARE_REVISION = 4'h0;
    localparam logic [3:0] OFS_TRANSACTION_CONTROL = 4'h1;
    localparam logic [3:0] OFS_TRANSACTION_CODE = 4'h2;
    localparam logic [3:0] OFS_TX_EEPROM_LOCATION = 4'h3;
    localparam logic [3:0] OFS_TX_EEPROM_VALUE = 4'h4;
    localparam logic [3:0] OFS_SINGLE_TURN_POSITION = 4'h5;
    localparam logic [3:0] OFS_TURN_COUNT = 4'h6;
    localparam logic [3:0] OFS_CONTROL_FIELD_ECHO = 4'h7;
    localparam logic [3:0] OFS_ENCODER_STATUS_FIELD = 4'h8;
    localparam logic [3:0] OFS_ENCODER_IDENTIFIER = 4'h9;
    localparam logic [3:0] OFS_ENCODER_FAULT_BYTE = 4'hA;
    localparam logic [3:0] OFS_RX_EEPROM_LOCATION = 4'hB;
    localparam logic [3:0] OFS_RX_EEPROM_VALUE = 4'hC;
    localparam logic [3:0] OFS_RECEIVED_CHECK_BYTE = 4'hD;

    // transaction_control fields
    localparam int unsigned CTRL_GO_BIT = 0;
    localparam int unsigned CTRL_PASS_BIT = 1;

    // reset values; revision value is arbitrary
    localparam logic [31:0] FIRMWARE_REVISION_VAL = 32'h0000_0001;
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [23:0] WORD_RST = 24'h00_0000;
    localparam logic [7:0] CRC_INIT = 8'h00;

    // control field layout: parity, code nibble, sync pattern
    localparam logic [2:0] CF_SYNC = 3'h2;

    // transaction codes
    localparam logic [7:0] CODE_READ_SINGLE_TURN = 8'h00;
    localparam logic [7:0] CODE_READ_TURN_COUNT = 8'h01;
    localparam logic [7:0] CODE_READ_IDENTIFIER = 8'h02;
    localparam logic [7:0] CODE_READ_ALL = 8'h03;
    localparam logic [7:0] CODE_EEPROM_WRITE = 8'h06;
    localparam logic [7:0] CODE_RESET_ERRORS = 8'h07;
    localparam logic [7:0] CODE_RESET_SINGLE_TURN = 8'h08;
    localparam logic [7:0] CODE_RESET_TURN_COUNT = 8'h0C;
    localparam logic [7:0] CODE_EEPROM_READ = 8'h0D;

    typedef enum logic [3:0] {
        FLD_NONE, FLD_CF, FLD_SF, FLD_ABS0, FLD_ABS1, FLD_ABS2,
        FLD_ABM0, FLD_ABM1, FLD_ABM2, FLD_ENID, FLD_ALMC, FLD_LOC, FLD_VAL
    } elr_field_t;

    typedef enum logic [2:0] {
        ST_INIT = 3'b000,
        ST_IDLE = 3'b001,
        ST_SETUP = 3'b011,
        ST_SEND = 3'b010,
        ST_ECHO = 3'b110,
        ST_RECV = 3'b111,
        ST_PARSE = 3'b101,
        ST_DONE = 3'b100
    } elr_state_t;
endpackage
`default_nettype wire

// File: hdl/elr_byte_buf.sv
// receive buffer: 16 bytes, one write port, registered read
`default_nettype none
module elr_byte_buf (
    input wire logic core_clk_i,
    input wire logic we_i,
    input wire logic [3:0] waddr_i,
    input wire logic [7:0] wdata_i,
    input wire logic [3:0] raddr_i,
    output logic [7:0] rdata_o
);
    logic [7:0] mem_q [16];

    always_ff @(posedge core_clk_i) begin
        if (we_i) begin
            mem_q[waddr_i] <= wdata_i;
        end
        rdata_o <= mem_q[raddr_i];
    end
endmodule // elr_byte_buf
`default_nettype wire

// File: hdl/elr_receiver.sv
// encoder link receiver: register port, 8N1 half-duplex link, reply parser
`default_nettype none
module elr_receiver
    import elr_pkg::*;
#(
    parameter logic [7:0] CRC_POLY = 8'h07,
    parameter int unsigned POS_BITS = 24
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    output logic [31:0] rd_data_o,
    input wire logic ser_rx_i,
    output logic ser_tx_o,
    output logic driver_enable_output_o
);
    localparam logic [23:0] POS_MASK = {24{1'b1}} >> (24 - POS_BITS);

    function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
        logic [7:0] r;
        logic fb;
        r = c;
        for (int i = 7; i >= 0; i--) begin
            fb = r[7] ^ d[i];
            r = {r[6:0], 1'b0} ^ (fb ? CRC_POLY : 8'h00);
        end
        return r;
    endfunction

    function automatic logic [2:0] tx_len_of(input logic [7:0] c);
        case (c)
            CODE_READ_SINGLE_TURN, CODE_READ_TURN_COUNT, CODE_READ_IDENTIFIER,
            CODE_READ_ALL, CODE_RESET_ERRORS, CODE_RESET_SINGLE_TURN,
            CODE_RESET_TURN_COUNT: return 3'h1;
            CODE_EEPROM_WRITE: return 3'h4;
            CODE_EEPROM_READ: return 3'h3;
            default: return 3'h0;
        endcase
    endfunction

    function automatic logic [3:0] reply_len_of(input logic [7:0] c);
        case (c)
            CODE_READ_IDENTIFIER, CODE_EEPROM_WRITE, CODE_EEPROM_READ: return 4'h4;
            CODE_READ_ALL: return 4'hB;
            default: return 4'h6;
        endcase
    endfunction

    // reply layouts, position counted from the control field echo
    function automatic elr_field_t field_at(input logic [7:0] c, input logic [3:0] p);
        elr_field_t f;
        f = FLD_NONE;
        if (p == 4'h0) begin
            f = FLD_CF;
        end else begin
            case (c)
                CODE_EEPROM_WRITE, CODE_EEPROM_READ:
                    f = (p == 4'h1) ? FLD_LOC : (p == 4'h2) ? FLD_VAL : FLD_NONE;
                CODE_READ_TURN_COUNT:
                    f = (p == 4'h1) ? FLD_SF : (p == 4'h2) ? FLD_ABM0 :
                        (p == 4'h3) ? FLD_ABM1 : (p == 4'h4) ? FLD_ABM2 : FLD_NONE;
                CODE_READ_IDENTIFIER:
                    f = (p == 4'h1) ? FLD_SF : (p == 4'h2) ? FLD_ENID : FLD_NONE;
                CODE_READ_ALL:
                    f = (p == 4'h1) ? FLD_SF : (p == 4'h2) ? FLD_ABS0 :
                        (p == 4'h3) ? FLD_ABS1 : (p == 4'h4) ? FLD_ABS2 :
                        (p == 4'h5) ? FLD_ENID : (p == 4'h6) ? FLD_ABM0 :
                        (p == 4'h7) ? FLD_ABM1 : (p == 4'h8) ? FLD_ABM2 :
                        (p == 4'h9) ? FLD_ALMC : FLD_NONE;
                default:
                    f = (p == 4'h1) ? FLD_SF : (p == 4'h2) ? FLD_ABS0 :
                        (p == 4'h3) ? FLD_ABS1 : (p == 4'h4) ? FLD_ABS2 : FLD_NONE;
            endcase
        end
        return f;
    endfunction

    elr_state_t state_q, state_d;
    logic go_q, pass_q, de_q;
    logic [7:0] code_q, tx_loc_q, tx_val_q, run_code_q;
    logic [23:0] abs_q, abm_q;
    logic [7:0] cf_q, sf_q, enid_q, almc_q, rx_loc_q, rx_val_q, crc_rx_q, crc_q;
    logic [7:0] tbuf_q [4];
    logic [2:0] tx_len_q;
    logic [3:0] rx_len_q, idx_q, wr_idx_q, rd_idx_q, pj_q;
    logic pv_q;
    logic [9:0] tmo_q;
    logic [31:0] rd_data_q;
    logic [9:0] tx_sh_q;
    logic [2:0] tx_cyc_q, rx_cyc_q;
    logic [3:0] tx_bits_q, rx_bits_q;
    logic tx_busy_q, rx_busy_q, rxv_q;
    logic [7:0] rx_sh_q, rxh_q;
    logic [7:0] buf_rdata;

    // request assembly
    wire [7:0] cf_byte = {^code_q[3:0], code_q[3:0], CF_SYNC};
    wire [7:0] crc_two = crc_step(crc_step(CRC_INIT, cf_byte), tx_loc_q);
    wire [7:0] crc_three = crc_step(crc_two, tx_val_q);
    wire [2:0] tx_len_w = tx_len_of(code_q);
    wire is_wr = (code_q == CODE_EEPROM_WRITE);

    // event decode
    wire new_byte = rx_busy_q && (rx_cyc_q == 3'h0) && (rx_bits_q == 4'h9) && ser_rx_i;
    wire tx_load = (state_q == ST_SEND) && !tx_busy_q;
    wire echo_take = (state_q == ST_ECHO) && rxv_q && !tx_busy_q;
    wire reply_take = (state_q == ST_RECV) && rxv_q;
    wire take = echo_take || reply_take;
    wire last_req = (idx_q == {1'b0, tx_len_q - 3'h1});
    wire last_rx = (wr_idx_q == rx_len_q - 4'h1);
    wire tmo_hit = (tmo_q == TIMEOUT_LAST);
    wire waiting = (state_q == ST_ECHO) || (state_q == ST_RECV);
    wire parse_last = pv_q && (pj_q == rx_len_q - 4'h1);
    wire [3:0] rel_pos = pj_q - {1'b0, tx_len_q};
    wire elr_field_t fld = field_at(run_code_q, rel_pos);
    wire flush = (state_q == ST_INIT) || (state_q == ST_SETUP);

    // register port decode
    wire wr_ctrl = wr_i && (addr_i == OFS_TRANSACTION_CONTROL);
    wire wr_code = wr_i && (addr_i == OFS_TRANSACTION_CODE);
    wire wr_loc = wr_i && (addr_i == OFS_TX_EEPROM_LOCATION);
    wire wr_val = wr_i && (addr_i == OFS_TX_EEPROM_VALUE);
    wire host_go = wr_ctrl && wdata_i[CTRL_GO_BIT];
    wire [7:0] ctrl_byte = {6'h00, pass_q, go_q};
    wire [31:0] rd_sel =
        (addr_i == OFS_FIRMWARE_REVISION) ? FIRMWARE_REVISION_VAL :
        (addr_i == OFS_TRANSACTION_CONTROL) ? {24'h00_0000, ctrl_byte} :
        (addr_i == OFS_TRANSACTION_CODE) ? {24'h00_0000, code_q} :
        (addr_i == OFS_TX_EEPROM_LOCATION) ? {24'h00_0000, tx_loc_q} :
        (addr_i == OFS_TX_EEPROM_VALUE) ? {24'h00_0000, tx_val_q} :
        (addr_i == OFS_SINGLE_TURN_POSITION) ? {8'h00, abs_q & POS_MASK} :
        (addr_i == OFS_TURN_COUNT) ? {8'h00, abm_q} :
        (addr_i == OFS_CONTROL_FIELD_ECHO) ? {24'h00_0000, cf_q} :
        (addr_i == OFS_ENCODER_STATUS_FIELD) ? {24'h00_0000, sf_q} :
        (addr_i == OFS_ENCODER_IDENTIFIER) ? {24'h00_0000, enid_q} :
        (addr_i == OFS_ENCODER_FAULT_BYTE) ? {24'h00_0000, almc_q} :
        (addr_i == OFS_RX_EEPROM_LOCATION) ? {24'h00_0000, rx_loc_q} :
        (addr_i == OFS_RX_EEPROM_VALUE) ? {24'h00_0000, rx_val_q} :
        (addr_i == OFS_RECEIVED_CHECK_BYTE) ? {24'h00_0000, crc_rx_q} :
        32'h0000_0000;

    assign rd_data_o = rd_data_q;
    assign ser_tx_o = tx_sh_q[0];
    assign driver_enable_output_o = de_q;

    always_comb begin
        state_d = state_q;
        case (state_q)
            ST_INIT: state_d = ST_IDLE;
            ST_IDLE: if (go_q) state_d = ST_SETUP;
            ST_SETUP: state_d = (tx_len_w == 3'h0) ? ST_DONE : ST_SEND;
            ST_SEND: if (!tx_busy_q) state_d = ST_ECHO;
            ST_ECHO: begin
                if (echo_take) begin
                    state_d = last_req ? ST_RECV : ST_SEND;
                end else if (tmo_hit) begin
                    state_d = ST_DONE;
                end
            end
            ST_RECV: begin
                if (reply_take && last_rx) begin
                    state_d = ST_PARSE;
                end else if (tmo_hit) begin
                    state_d = ST_DONE;
                end
            end
            ST_PARSE: if (parse_last) state_d = ST_DONE;
            ST_DONE: state_d = ST_IDLE;
            default: state_d = ST_INIT;
        endcase
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            state_q <= ST_INIT;
            rd_data_q <= 32'h0000_0000;
        end else begin
            state_q <= state_d;
            rd_data_q <= rd_i ? rd_sel : 32'h0000_0000;
        end
    end

    // host-owned registers; go set by host wins over the completion clear
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            go_q <= 1'b0;
            code_q <= BYTE_RST;
            tx_loc_q <= BYTE_RST;
            tx_val_q <= BYTE_RST;
        end else begin
            if (host_go) begin
                go_q <= 1'b1;
            end else if (state_q == ST_DONE) begin
                go_q <= 1'b0;
            end
            if (wr_code) code_q <= wdata_i[7:0];
            if (wr_loc) tx_loc_q <= wdata_i[7:0];
            if (wr_val) tx_val_q <= wdata_i[7:0];
        end
    end

    // request setup and link sequencing
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            de_q <= 1'b0;
            run_code_q <= BYTE_RST;
            tx_len_q <= 3'h0;
            rx_len_q <= 4'h0;
            idx_q <= 4'h0;
            wr_idx_q <= 4'h0;
            tmo_q <= 10'h000;
            for (int i = 0; i < 4; i++) tbuf_q[i] <= BYTE_RST;
        end else begin
            if (state_q == ST_SETUP) begin
                run_code_q <= code_q;
                tx_len_q <= tx_len_w;
                rx_len_q <= {1'b0, tx_len_w} + reply_len_of(code_q);
                tbuf_q[0] <= cf_byte;
                tbuf_q[1] <= tx_loc_q;
                tbuf_q[2] <= is_wr ? tx_val_q : crc_two;
                tbuf_q[3] <= crc_three;
                idx_q <= 4'h0;
                wr_idx_q <= 4'h0;
                de_q <= (tx_len_w != 3'h0);
            end
            if (take) begin
                wr_idx_q <= wr_idx_q + 4'h1;
            end
            if (echo_take) begin
                idx_q <= idx_q + 4'h1;
                if (last_req) de_q <= 1'b0;
            end
            // a silent encoder must not hang the host
            if (tmo_hit || state_q == ST_DONE) de_q <= 1'b0;
            tmo_q <= (waiting && !take) ? tmo_q + 10'h001 : 10'h000;
        end
    end

    // reply parse and check comparison
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rd_idx_q <= 4'h0;
            pj_q <= 4'h0;
            pv_q <= 1'b0;
            crc_q <= CRC_INIT;
            pass_q <= 1'b0;
        end else if (state_q == ST_PARSE) begin
            rd_idx_q <= rd_idx_q + 4'h1;
            pj_q <= rd_idx_q;
            pv_q <= 1'b1;
            if (pv_q && !parse_last) crc_q <= crc_step(crc_q, buf_rdata);
            if (parse_last) pass_q <= (crc_q == buf_rdata);
        end else begin
            rd_idx_q <= {1'b0, tx_len_q};
            pv_q <= 1'b0;
            if (state_q == ST_SETUP) begin
                crc_q <= CRC_INIT;
                pass_q <= 1'b0;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            abs_q <= WORD_RST;
            abm_q <= WORD_RST;
            cf_q <= BYTE_RST;
            sf_q <= BYTE_RST;
            enid_q <= BYTE_RST;
            almc_q <= BYTE_RST;
            rx_loc_q <= BYTE_RST;
            rx_val_q <= BYTE_RST;
            crc_rx_q <= BYTE_RST;
        end else if (state_q == ST_PARSE && pv_q) begin
            if (parse_last) begin
                crc_rx_q <= buf_rdata;
            end else begin
                case (fld)
                    FLD_CF: cf_q <= buf_rdata;
                    FLD_SF: sf_q <= buf_rdata;
                    FLD_ABS0: abs_q[7:0] <= buf_rdata;
                    FLD_ABS1: abs_q[15:8] <= buf_rdata;
                    FLD_ABS2: abs_q[23:16] <= buf_rdata;
                    FLD_ABM0: abm_q[7:0] <= buf_rdata;
                    FLD_ABM1: abm_q[15:8] <= buf_rdata;
                    FLD_ABM2: abm_q[23:16] <= buf_rdata;
                    FLD_ENID: enid_q <= buf_rdata;
                    FLD_ALMC: almc_q <= buf_rdata;
                    FLD_LOC: rx_loc_q <= buf_rdata;
                    FLD_VAL: rx_val_q <= buf_rdata;
                    default: ;
                endcase
            end
        end
    end

    // transmitter: start, eight data bits LSB first, stop
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_sh_q <= 10'h3FF;
            tx_busy_q <= 1'b0;
            tx_cyc_q <= 3'h0;
            tx_bits_q <= 4'h0;
        end else if (tx_load) begin
            tx_sh_q <= {1'b1, tbuf_q[idx_q[1:0]], 1'b0};
            tx_busy_q <= 1'b1;
            tx_cyc_q <= BIT_LAST;
            tx_bits_q <= 4'h0;
        end else if (tx_busy_q) begin
            if (tx_cyc_q == 3'h0) begin
                tx_sh_q <= {1'b1, tx_sh_q[9:1]};
                tx_cyc_q <= BIT_LAST;
                tx_bits_q <= tx_bits_q + 4'h1;
                if (tx_bits_q == FRAME_BITS - 4'h1) tx_busy_q <= 1'b0;
            end else begin
                tx_cyc_q <= tx_cyc_q - 3'h1;
            end
        end
    end

    // receiver, always listening, sampled mid-bit; bad stop bit drops the byte
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_busy_q <= 1'b0;
            rx_cyc_q <= 3'h0;
            rx_bits_q <= 4'h0;
            rx_sh_q <= BYTE_RST;
        end else if (!rx_busy_q) begin
            if (!ser_rx_i) begin
                rx_busy_q <= 1'b1;
                rx_cyc_q <= HALF_LAST;
                rx_bits_q <= 4'h0;
            end
        end else if (rx_cyc_q == 3'h0) begin
            rx_cyc_q <= BIT_LAST;
            rx_bits_q <= rx_bits_q + 4'h1;
            if (rx_bits_q == 4'h0 && ser_rx_i) rx_busy_q <= 1'b0;
            if (rx_bits_q != 4'h0 && rx_bits_q != 4'h9) rx_sh_q <= {ser_rx_i, rx_sh_q[7:1]};
            if (rx_bits_q == 4'h9) rx_busy_q <= 1'b0;
        end else begin
            rx_cyc_q <= rx_cyc_q - 3'h1;
        end
    end

    // one-byte receive holding stage; stale bytes flushed before each request
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rxv_q <= 1'b0;
            rxh_q <= BYTE_RST;
        end else if (new_byte) begin
            rxv_q <= 1'b1;
            rxh_q <= rx_sh_q;
        end else if (flush || take) begin
            rxv_q <= 1'b0;
        end
    end

    elr_byte_buf u_rx_buf (
        .core_clk_i(core_clk_i),
        .we_i(take),
        .waddr_i(wr_idx_q),
        .wdata_i(rxh_q),
        .raddr_i(rd_idx_q),
        .rdata_o(buf_rdata)
    );
endmodule // elr_receiver
`default_nettype wire

// File: verif/elr_receiver_chk.sv
// port checker for the encoder link receiver
`default_nettype none
module elr_receiver_chk
    import elr_pkg::*;
#(
    parameter int unsigned POS_BITS = 24
) (
    input wire logic core_clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] addr_i,
    input wire logic [31:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [31:0] rd_data_o,
    input wire logic ser_rx_i,
    input wire logic ser_tx_o,
    input wire logic driver_enable_output_o
);
    localparam logic [31:0] POS_MASK = 32'((64'h1 << POS_BITS) - 64'h1);
    // position inside an outgoing character, 0 while the line idles
    logic [6:0] cnt_q;
    logic [6:0] cnt_d;
    logic tx_q;
    wire de = driver_enable_output_o;
    assign cnt_d = (cnt_q == 7'h4F) ? 7'h00 : (cnt_q != 7'h00) ? cnt_q + 7'h01
        : {6'h00, tx_q & ~ser_tx_o};
    always_ff @(posedge core_clk_i) begin
        cnt_q <= rst_n_i ? cnt_d : 7'h00;
        tx_q <= rst_n_i ? ser_tx_o : 1'b1;
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (!rst_n_i);
    a_reset_idle: assert property (disable iff (1'b0) !rst_n_i |=> !de && ser_tx_o)
        else $error("line not idle after reset");
    a_tx_needs_enable: assert property (!de |-> ser_tx_o)
        else $error("transmit active with driver off");
    a_start_after_enable: assert property ($rose(de) |-> ##[1:2] !ser_tx_o)
        else $error("no start bit after driver enable");
    a_bit_hold: assert property (cnt_q != 7'h00 && cnt_q[2:0] != 3'h0 |-> $stable(ser_tx_o))
        else $error("bit shorter than eight clocks");
    a_stop_high: assert property (cnt_q >= 7'h48 |-> ser_tx_o)
        else $error("stop bit not high");
    a_release_after_stop: assert property ($fell(de) |-> ser_tx_o && $past(ser_tx_o, 8))
        else $error("driver released inside a character");
    a_rdata_quiet: assert property (!$past(rd_i) |-> rd_data_o == 32'h0)
        else $error("read data outside its cycle");
    a_unmapped_zero: assert property (rd_i && addr_i > OFS_RECEIVED_CHECK_BYTE |=>
        rd_data_o == 32'h0) else $error("unmapped index reads nonzero");
    a_position_top_zero: assert property (rd_i && addr_i == OFS_SINGLE_TURN_POSITION |=>
        (rd_data_o & ~POS_MASK) == 32'h0) else $error("position unused bits set");
    c_frame_sent: cover property (cnt_q == 7'h4F);
    c_driver_released: cover property ($fell(de));
    c_pass_read: cover property (rd_i && addr_i == OFS_TRANSACTION_CONTROL ##1 rd_data_o[1]);
endmodule // elr_receiver_chk
bind elr_receiver elr_receiver_chk #(.POS_BITS(POS_BITS)) u_chk (.core_clk_i(core_clk_i),
    .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i),
    .rd_data_o(rd_data_o), .ser_rx_i(ser_rx_i), .ser_tx_o(ser_tx_o),
    .driver_enable_output_o(driver_enable_output_o));
`default_nettype wire

// File: verif/elr_enc_model.sv
// behavioural position encoder on the shared half-duplex line
`default_nettype none
module elr_enc_model #(
    parameter logic [7:0] POLY = 8'h07
) (
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic de_i,
    input wire logic bad_i,
    input wire logic [7:0] base_i,
    input wire logic [9:0] gap_i,
    output logic drv_o,
    output logic tx_o
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] req [4];
    logic [7:0] rep [11];
    logic [7:0] c;
    logic [3:0] code;
    int n_req;
    int n_rep;
    function automatic logic [7:0] crc8(input logic [7:0] s, input logic [7:0] d);
        s = s ^ d;
        for (int k = 0; k < 8; k++) s = s[7] ? {s[6:0], 1'b0} ^ POLY : {s[6:0], 1'b0};
        return s;
    endfunction
    initial begin
        drv_o = 1'b0;
        tx_o = 1'b1;
        forever begin
            @(posedge de_i);
            n_req = 0;
            while (de_i) begin
                @(negedge line_i or negedge de_i);
                if (de_i) begin
                    // sample mid-bit; negedge keeps clear of the launching edge
                    repeat (4) @(negedge clk_i);
                    for (int i = 0; i < 8; i++) begin
                        repeat (8) @(negedge clk_i);
                        req[n_req][i] = line_i;
                    end
                    repeat (8) @(negedge clk_i);
                    n_req++;
                end
            end
            code = req[0][6:3];
            n_rep = (code == 4'h3) ? 11 : (code == 4'h2 || code == 4'h6 || code == 4'hD) ? 4 : 6;
            rep[0] = req[0];
            c = crc8(8'h00, rep[0]);
            for (int j = 1; j < n_rep - 1; j++) begin
                rep[j] = base_i + 8'(j);
                c = crc8(c, rep[j]);
            end
            rep[n_rep - 1] = bad_i ? ~c : c;
            repeat (gap_i) @(posedge clk_i);
            drv_o <= 1'b1;
            for (int j = 0; j < n_rep; j++) begin
                for (int b = 0; b < 10; b++) begin
                    tx_o <= (b == 0) ? 1'b0 : (b == 9) ? 1'b1 : rep[j][b - 1];
                    repeat (8) @(posedge clk_i);
                end
            end
            drv_o <= 1'b0;
        end
    end
endmodule // elr_enc_model
`default_nettype wire

// File: verif/elr_receiver_tb.sv
// self-checking bench for the encoder link receiver
`default_nettype none
module elr_receiver_tb
    import elr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, wr, rd, de, tx, drv, etx, bad;
    logic [3:0] addr;
    logic [31:0] wdata, rdat;
    logic [7:0] base;
    logic [9:0] gap;
    logic [7:0] r [11];
    // released line rests high through the bus bias
    wire line = de ? tx : (drv ? etx : 1'b1);
    int n_fail = 0, compares = 0, cyc = 0, n_de = 0;
    logic [7:0] codes [9] = '{CODE_READ_SINGLE_TURN, CODE_READ_TURN_COUNT, CODE_READ_IDENTIFIER,
        CODE_READ_ALL, CODE_EEPROM_WRITE, CODE_RESET_ERRORS, CODE_RESET_SINGLE_TURN,
        CODE_RESET_TURN_COUNT, CODE_EEPROM_READ};
    elr_receiver dut (.core_clk_i(clk), .rst_n_i(rst_n), .addr_i(addr), .wdata_i(wdata),
        .wr_i(wr), .rd_i(rd), .rd_data_o(rdat), .ser_rx_i(line), .ser_tx_o(tx),
        .driver_enable_output_o(de));
    elr_enc_model enc (.clk_i(clk), .line_i(line), .de_i(de), .bad_i(bad), .base_i(base),
        .gap_i(gap), .drv_o(drv), .tx_o(etx));
    always #25 clk = ~clk;
    always @(posedge de) n_de++;
    always @(posedge clk) begin
        cyc++;
        if (cyc == 60000) begin
            n_fail++;
            test_done();
        end
    end
    task automatic test_done();
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        compares++;
        if (got !== exp) begin
            n_fail++;
            $display("[FAIL] %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic wr_reg(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wr <= 1'b1;
        addr <= a;
        wdata <= d;
        @(posedge clk);
        wr <= 1'b0;
    endtask
    task automatic chk_reg(input logic [3:0] a, input logic [31:0] e);
        @(posedge clk);
        rd <= 1'b1;
        addr <= a;
        @(posedge clk);
        rd <= 1'b0;
        #1 check(rdat, e);
    endtask
    function automatic logic [31:0] w3(input int i);
        return {8'h00, r[i + 2], r[i + 1], r[i]};
    endfunction
    task automatic run(input logic [7:0] code, input logic pass);
        wr_reg(OFS_TRANSACTION_CODE, 32'(code));
        wr_reg(OFS_TRANSACTION_CONTROL, 32'h1);
        for (int t = 0; t < 3000; t++) begin
            @(posedge clk);
            rd <= 1'b1;
            addr <= OFS_TRANSACTION_CONTROL;
            @(posedge clk);
            rd <= 1'b0;
            #1 if (rdat[0] === 1'b0) break;
        end
        check(rdat, {30'h0, pass, 1'b0});
    endtask
    task automatic fields(input logic [7:0] c);
        int n;
        r = enc.rep;
        n = enc.n_rep;
        check(32'(enc.req[0]), {24'h0, ^c[3:0], c[3:0], CF_SYNC});
        chk_reg(OFS_CONTROL_FIELD_ECHO, 32'(r[0]));
        chk_reg(OFS_RECEIVED_CHECK_BYTE, 32'(r[n - 1]));
        if (c == CODE_EEPROM_WRITE || c == CODE_EEPROM_READ) begin
            check(32'(enc.n_req), (c == CODE_EEPROM_WRITE) ? 32'h4 : 32'h3);
            check(32'(enc.req[1]), 32'h5A);
            if (c == CODE_EEPROM_WRITE) check(32'(enc.req[2]), 32'hC3);
            chk_reg(OFS_RX_EEPROM_LOCATION, 32'(r[1]));
            chk_reg(OFS_RX_EEPROM_VALUE, 32'(r[2]));
        end else begin
            check(32'(enc.n_req), 32'h1);
            chk_reg(OFS_ENCODER_STATUS_FIELD, 32'(r[1]));
        end
        if (c == CODE_READ_TURN_COUNT)
            chk_reg(OFS_TURN_COUNT, w3(2));
        else if (c == CODE_READ_IDENTIFIER)
            chk_reg(OFS_ENCODER_IDENTIFIER, 32'(r[2]));
        else if (c == CODE_READ_ALL) begin
            chk_reg(OFS_SINGLE_TURN_POSITION, w3(2));
            chk_reg(OFS_ENCODER_IDENTIFIER, 32'(r[5]));
            chk_reg(OFS_TURN_COUNT, w3(6));
            chk_reg(OFS_ENCODER_FAULT_BYTE, 32'(r[9]));
        end else if (n == 6)
            chk_reg(OFS_SINGLE_TURN_POSITION, w3(2));
    endtask
    initial begin
        int de_seen;
        clk = 1'b0;
        rst_n = 1'b0;
        {wr, rd, bad, addr, wdata} = '0;
        base = 8'h20;
        gap = 10'h003;
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        wr_reg(4'hE, 32'hFF);
        for (int a = 0; a < 16; a++) chk_reg(4'(a), (a == 0) ? FIRMWARE_REVISION_VAL : 32'h0);
        wr_reg(OFS_SINGLE_TURN_POSITION, 32'hFF);
        chk_reg(OFS_SINGLE_TURN_POSITION, 32'h0);
        wr_reg(OFS_TX_EEPROM_LOCATION, 32'h5A);
        wr_reg(OFS_TX_EEPROM_VALUE, 32'hC3);
        chk_reg(OFS_TX_EEPROM_VALUE, 32'hC3);
        $display("test registers done");
        foreach (codes[i]) begin
            base = 8'h20 + 8'(i * 16);
            // a slow encoder answer on one code, still inside the reply timeout
            gap = (i == 3) ? 10'h258 : 10'h003;
            run(codes[i], 1'b1);
            fields(codes[i]);
            $display("test code %h done", codes[i]);
        end
        bad = 1'b1;
        run(CODE_READ_SINGLE_TURN, 1'b0);
        fields(CODE_READ_SINGLE_TURN);
        bad = 1'b0;
        de_seen = n_de;
        run(8'h04, 1'b0);
        check(32'(n_de), 32'(de_seen));
        $display("test bad check and unknown code done");
        gap = 10'h384;
        run(CODE_READ_TURN_COUNT, 1'b0);
        repeat (1200) @(posedge clk);
        gap = 10'h003;
        run(CODE_READ_TURN_COUNT, 1'b1);
        fields(CODE_READ_TURN_COUNT);
        $display("test reply timeout done");
        test_done();
    end
endmodule // elr_receiver_tb
`default_nettype wire
